// *** hw/anpd_core.sv ***
// Parallel detection, fault signalling and restart control with AXI registers.
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module anpd_core
	import anpd_pkg::*;
#(
	parameter int unsigned NEG_CYC = NEG_TIMEOUT_CYC
)
(
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// AXI4-Lite write channels.
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic      [1:0]  bresp,
	// AXI4-Lite read channels.
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic      [31:0] rdata,
	output logic      [1:0]  rresp,
	// Line events from the pulse decoder.
	input  wire logic        rx_flp,
	input  wire logic        rx_nlp,
	input  wire logic        rx_idle100,
	input  wire logic        rx_signal,
	input  wire logic        rx_remote_fault,
	input  wire logic        page_rcvd,
	input  wire logic        ack_rcvd,
	// Resolution result and link state.
	input  wire logic        res_100,
	input  wire logic        res_fdx,
	input  wire logic        link_ok,
	input  wire logic        local_link_fault,
	// Technology enables and transmit control.
	output logic             flp_tx_en,
	output logic             tech_10_en,
	output logic             tech_100_en,
	output logic             adv_remote_fault
);

	anpd_st_t    s_r;
	anpd_st_t    s_nxt;
	logic [3:0]  held;
	logic [3:0]  arb_code;
	logic        arb_done;
	logic        rd_qp;
	logic        rd_exp;
	logic        multi;
	logic        tmo;
	logic        quiet;
	logic [15:0] rv;
	logic [1:0]  rerr;

	// Maps each arbitration state to its progress code.
	function automatic logic [3:0] anpd_code(input anpd_arb_t a);
		case (a)
			ARB_TXFLP: anpd_code = PM_TXFLP;
			ARB_ABIL:  anpd_code = PM_ABIL;
			ARB_ACK:   anpd_code = PM_ACK;
			ARB_NLP:   anpd_code = PM_NLP;
			ARB_I100:  anpd_code = PM_I100;
			ARB_PDF:   anpd_code = PM_PDF;
			ARB_LWAIT: anpd_code = PM_LWAIT;
			ARB_DONE:  anpd_code = PM_DONE;
			default:   anpd_code = PM_IDLE;
		endcase
	endfunction: anpd_code

	// Helper terms for the state machine.
	assign arb_code = anpd_code(s_r.neg.arb);
	assign arb_done = (s_r.neg.arb == ARB_DONE);
	assign multi = (rx_flp && rx_nlp) || (rx_flp && rx_idle100) ||
		(rx_nlp && rx_idle100);
	assign tmo = (s_r.neg.tmr >= 23'(NEG_CYC - 1));
	assign quiet = s_r.an_en && !s_r.rst_req && !s_r.srst;

	// Progress monitor with history-then-present reads.
	anpd_progress u_pm (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.clr     (s_r.srst),
		.rd      (rd_qp),
		.done    (arb_done),
		.code    (arb_code),
		.held    (held)
	);

	// Read multiplexer over the current register contents.
	always_comb
	begin
		rv = 16'h0000;
		rerr = RESP_OKAY;
		case (araddr)
			REG_CTRL: rv[CTRL_ANEN] = s_r.an_en;
			REG_STAT:
			begin
				rv[STAT_LINK] = link_ok;
				rv[STAT_RF] = s_r.neg.rf;
				rv[STAT_DONE] = arb_done;
			end
			REG_PART:
			begin
				rv[PART_10HD] = s_r.neg.partner_10hd;
				rv[PART_100HD] = s_r.neg.partner_100hd;
				rv[PART_RF] = s_r.neg.rf;
			end
			REG_ADV: rv[ADV_RF] = s_r.neg.adv_rf;
			REG_EXP:
			begin
				rv[EXP_CAP] = s_r.neg.partner_negotiation_capable;
				rv[EXP_PDF] = s_r.neg.pd_fault;
			end
			REG_QP:
			begin
				rv[QP_RATE] = s_r.neg.rate100;
				rv[QP_DPX] = s_r.neg.fdx;
				rv[QP_PROG_HI:QP_PROG_LO] = held[2:0];
				rv[QP_DONE] = held[3];
				rv[QP_NOSIG] = s_r.neg.no_sig;
				rv[QP_RF] = s_r.neg.rf;
				rv[QP_LINK] = link_ok;
			end
			REG_EXT: rv[EXT_RF] = s_r.neg.rf;
			default: rerr = RESP_SLVERR;
		endcase
	end

	// Next state: bus slave, then negotiation machine.
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.rst_req = 1'b0;
		s_nxt.srst = 1'b0;
		rd_qp = 1'b0;
		rd_exp = 1'b0;
		if (awvalid && awready)
		begin
			s_nxt.aw_ok = 1'b1;
			s_nxt.waddr = awaddr;
		end
		if (wvalid && wready)
		begin
			s_nxt.w_ok = 1'b1;
			s_nxt.wdata = wdata[15:0];
			s_nxt.wstrb = wstrb[1:0];
		end
		if (s_r.bvalid && bready)
			s_nxt.bvalid = 1'b0;
		// A write acts once both address and data are held.
		if (s_r.aw_ok && s_r.w_ok)
		begin
			s_nxt.aw_ok = 1'b0;
			s_nxt.w_ok = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = (s_r.waddr > REG_EXT || s_r.waddr[1:0] != 2'h0) ?
				RESP_SLVERR : RESP_OKAY;
			if (s_r.waddr == REG_CTRL && s_r.wstrb[1])
			begin
				s_nxt.an_en = s_r.wdata[CTRL_ANEN];
				s_nxt.rst_req = s_r.wdata[CTRL_RESTART];
				s_nxt.srst = s_r.wdata[CTRL_SRST];
			end
		end
		if (s_r.rvalid && rready)
			s_nxt.rvalid = 1'b0;
		// Read data is captured as the address is taken.
		if (arvalid && arready)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = rv;
			s_nxt.rresp = rerr;
			rd_qp = (araddr == REG_QP);
			rd_exp = (araddr == REG_EXP);
		end
		if (s_r.srst)
		begin
			s_nxt.neg = NEG_RST;
			s_nxt.an_en = CTRL_RESET_VAL[CTRL_ANEN];
		end
		else
		begin
			if (rd_exp)
				s_nxt.neg.pd_fault = 1'b0;
			case (s_r.neg.arb)
				ARB_IDLE:
					if (s_r.an_en)
						s_nxt.neg.arb = ARB_TXFLP;
				ARB_TXFLP:
					if (multi)
					begin
						s_nxt.neg.arb = ARB_PDF;
						s_nxt.neg.pd_fault = 1'b1;
					end
					else if (rx_flp)
					begin
						s_nxt.neg.arb = ARB_ABIL;
						s_nxt.neg.partner_negotiation_capable = 1'b1;
					end
					else if (rx_nlp)
					begin
						s_nxt.neg.arb = ARB_NLP;
						s_nxt.neg.partner_negotiation_capable = 1'b0;
						s_nxt.neg.partner_10hd = 1'b1;
						s_nxt.neg.partner_100hd = 1'b0;
					end
					else if (rx_idle100)
					begin
						s_nxt.neg.arb = ARB_I100;
						s_nxt.neg.partner_negotiation_capable = 1'b0;
						s_nxt.neg.partner_100hd = 1'b1;
						s_nxt.neg.partner_10hd = 1'b0;
					end
				ARB_ABIL:
					if (page_rcvd)
						s_nxt.neg.arb = ARB_ACK;
					else if (tmo)
						s_nxt.neg.arb = ARB_TXFLP;
				ARB_ACK:
					if (ack_rcvd)
					begin
						s_nxt.neg.arb = ARB_LWAIT;
						s_nxt.neg.rate100 = res_100;
						s_nxt.neg.fdx = res_fdx;
						s_nxt.neg.tech100 = res_100;
						s_nxt.neg.tech10 = !res_100;
					end
					else if (tmo)
						s_nxt.neg.arb = ARB_TXFLP;
				ARB_NLP:
				begin
					s_nxt.neg.arb = ARB_LWAIT;
					s_nxt.neg.tech10 = 1'b1;
					s_nxt.neg.tech100 = 1'b0;
					s_nxt.neg.rate100 = 1'b0;
					s_nxt.neg.fdx = 1'b0;
				end
				ARB_I100:
				begin
					s_nxt.neg.arb = ARB_LWAIT;
					s_nxt.neg.tech100 = 1'b1;
					s_nxt.neg.tech10 = 1'b0;
					s_nxt.neg.rate100 = 1'b1;
					s_nxt.neg.fdx = 1'b0;
				end
				ARB_PDF:
				begin
					s_nxt.neg.tech10 = 1'b0;
					s_nxt.neg.tech100 = 1'b0;
					if (tmo)
						s_nxt.neg.arb = ARB_TXFLP;
				end
				ARB_LWAIT:
					if (link_ok)
						s_nxt.neg.arb = ARB_DONE;
					else if (tmo)
						s_nxt.neg.arb = ARB_TXFLP;
				ARB_DONE:
					if (!link_ok)
						s_nxt.neg.arb = ARB_TXFLP;
				default: s_nxt.neg.arb = ARB_IDLE;
			endcase
			// Budget timer restarts on every state change.
			if (s_nxt.neg.arb != s_r.neg.arb || tmo)
				s_nxt.neg.tmr = 23'h000000;
			else
				s_nxt.neg.tmr = s_r.neg.tmr + 23'h000001;
			// Restart request or disable sends arbitration back to idle.
			if (s_r.rst_req || !s_r.an_en)
			begin
				s_nxt.neg.arb = ARB_IDLE;
				s_nxt.neg.tmr = 23'h000000;
				s_nxt.neg.tech10 = 1'b0;
				s_nxt.neg.tech100 = 1'b0;
				s_nxt.neg.rf = 1'b0;
			end
			// A partner fault wins over the restart clear.
			if (rx_remote_fault)
				s_nxt.neg.rf = 1'b1;
			s_nxt.neg.no_sig = !rx_signal;
			s_nxt.neg.adv_rf = local_link_fault;
		end
	end

	// State register.
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			s_r <= ST_RST;
		else
			s_r <= s_nxt;
	end

	// Bus handshakes and outputs.
	assign awready = !s_r.aw_ok && !s_r.bvalid;
	assign wready = !s_r.w_ok && !s_r.bvalid;
	assign arready = !s_r.rvalid;
	assign bvalid = s_r.bvalid;
	assign bresp = s_r.bresp;
	assign rvalid = s_r.rvalid;
	assign rresp = s_r.rresp;
	assign rdata = {16'h0000, s_r.rdata};
	assign flp_tx_en = (s_r.neg.arb == ARB_TXFLP) ||
		(s_r.neg.arb == ARB_ABIL) || (s_r.neg.arb == ARB_ACK);
	assign tech_10_en = s_r.neg.tech10;
	assign tech_100_en = s_r.neg.tech100;
	assign adv_remote_fault = s_r.neg.adv_rf;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// Single-technology reception while listening to bursts.
	sequence seq_nlp_only;
		s_r.neg.arb == ARB_TXFLP && quiet && rx_nlp && !rx_flp && !rx_idle100;
	endsequence
	sequence seq_idle_only;
		s_r.neg.arb == ARB_TXFLP && quiet && rx_idle100 && !rx_flp && !rx_nlp;
	endsequence
	sequence seq_10_found;
		s_r.neg.partner_10hd && !s_r.neg.partner_negotiation_capable;
	endsequence

	AST_PD_10: assert property (seq_nlp_only |=> seq_10_found)
		else $error("Link pulses did not classify a 10M partner.");
	AST_PD_100: assert property (seq_idle_only ##1 quiet |=>
		tech_100_en && !tech_10_en)
		else $error("Idles did not enable only the 100M path.");
	AST_CAP: assert property (s_r.neg.arb == ARB_TXFLP && quiet &&
		rx_flp && !rx_nlp && !rx_idle100 |=>
		s_r.neg.partner_negotiation_capable)
		else $error("Burst reply did not mark partner capable.");
	AST_PDF: assert property (s_r.neg.arb == ARB_TXFLP && quiet &&
		multi |=> s_r.neg.pd_fault ##1 !tech_10_en && !tech_100_en)
		else $error("Mixed signals did not raise detection fault.");
	AST_RF: assert property (rx_remote_fault && !s_r.srst |=> s_r.neg.rf)
		else $error("Partner fault not recorded.");
	AST_START: assert property (s_r.neg.arb == ARB_IDLE && quiet |=>
		s_r.neg.arb == ARB_TXFLP ##0 flp_tx_en)
		else $error("Negotiation did not start while enabled.");
	AST_LINKFAIL: assert property (arb_done && quiet && !link_ok |=>
		s_r.neg.arb == ARB_TXFLP)
		else $error("Link loss did not restart negotiation.");
	AST_BUDGET: assert property (s_r.neg.tmr < 23'(NEG_CYC))
		else $error("Negotiation timer passed its budget.");

endmodule: anpd_core

// *** hw/anpd_pkg.sv ***
// Constants, register map and state types of the negotiation monitor block.
package anpd_pkg;

	// Register byte offsets on the AXI4-Lite bus.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_PART = 8'h08;
	localparam logic [7:0] REG_ADV  = 8'h0C;
	localparam logic [7:0] REG_EXP  = 8'h10;
	localparam logic [7:0] REG_QP   = 8'h14;
	localparam logic [7:0] REG_EXT  = 8'h18;

	// Control register fields and reset value.
	localparam int CTRL_SRST    = 15;
	localparam int CTRL_ANEN    = 12;
	localparam int CTRL_RESTART = 9;
	localparam logic [15:0] CTRL_RESET_VAL = 16'h1000;

	// Field positions of the status copies.
	localparam int STAT_LINK    = 2;
	localparam int STAT_RF      = 4;
	localparam int STAT_DONE    = 5;
	localparam int PART_10HD    = 5;
	localparam int PART_100HD   = 7;
	localparam int PART_RF      = 13;
	localparam int ADV_RF       = 13;
	localparam int EXP_CAP      = 0;
	localparam int EXP_PDF      = 4;
	localparam int EXT_RF       = 13;
	localparam int QP_RATE      = 15;
	localparam int QP_DPX       = 14;
	localparam int QP_PROG_HI   = 13;
	localparam int QP_PROG_LO   = 11;
	localparam int QP_DONE      = 4;
	localparam int QP_NOSIG     = 3;
	localparam int QP_RF        = 1;
	localparam int QP_LINK      = 0;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Negotiation time budget and its count of clock cycles.
	localparam int unsigned CLK_HZ          = 10000000;
	localparam int unsigned NEG_TIME_MS     = 500;
	localparam int unsigned NEG_TIMEOUT_CYC = NEG_TIME_MS * (CLK_HZ / 1000);

	// Progress codes, one for each arbitration state, and PM_UP for a read after completion.
	localparam logic [3:0] PM_IDLE  = 4'h0;
	localparam logic [3:0] PM_TXFLP = 4'h1;
	localparam logic [3:0] PM_ABIL  = 4'h2;
	localparam logic [3:0] PM_ACK   = 4'h3;
	localparam logic [3:0] PM_NLP   = 4'h4;
	localparam logic [3:0] PM_I100  = 4'h5;
	localparam logic [3:0] PM_PDF   = 4'h6;
	localparam logic [3:0] PM_LWAIT = 4'h7;
	localparam logic [3:0] PM_UP    = 4'h8;
	localparam logic [3:0] PM_DONE  = 4'hF;

	// Arbitration states, one-hot.
	typedef enum logic [8:0] {
		ARB_IDLE  = 9'h001,
		ARB_TXFLP = 9'h002,
		ARB_ABIL  = 9'h004,
		ARB_ACK   = 9'h008,
		ARB_NLP   = 9'h010,
		ARB_I100  = 9'h020,
		ARB_PDF   = 9'h040,
		ARB_LWAIT = 9'h080,
		ARB_DONE  = 9'h100
	} anpd_arb_t;

	// Negotiation state and status flags.
	typedef struct packed {
		anpd_arb_t   arb;
		logic [22:0] tmr;
		logic        partner_negotiation_capable;
		logic        partner_10hd;
		logic        partner_100hd;
		logic        pd_fault;
		logic        rf;
		logic        no_sig;
		logic        adv_rf;
		logic        tech10;
		logic        tech100;
		logic        rate100;
		logic        fdx;
	} anpd_neg_t;

	localparam anpd_neg_t NEG_RST = '{arb: ARB_IDLE, tmr: 23'h000000,
		partner_negotiation_capable: 1'b0, partner_10hd: 1'b0,
		partner_100hd: 1'b0, pd_fault: 1'b0, rf: 1'b0, no_sig: 1'b0,
		adv_rf: 1'b0, tech10: 1'b0, tech100: 1'b0, rate100: 1'b0,
		fdx: 1'b0};

	// Whole state of the top module.
	typedef struct packed {
		anpd_neg_t   neg;
		logic        an_en;
		logic        rst_req;
		logic        srst;
		logic        aw_ok;
		logic        w_ok;
		logic [7:0]  waddr;
		logic [15:0] wdata;
		logic [1:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [15:0] rdata;
	} anpd_st_t;

	localparam anpd_st_t ST_RST = '{neg: NEG_RST,
		an_en: CTRL_RESET_VAL[CTRL_ANEN], rst_req: 1'b0, srst: 1'b0,
		aw_ok: 1'b0, w_ok: 1'b0, waddr: 8'h00, wdata: 16'h0000,
		wstrb: 2'h0, bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0,
		rresp: RESP_OKAY, rdata: 16'h0000};

endpackage: anpd_pkg

// *** hw/anpd_progress.sv ***
// Progress monitor: history-then-present latch of the arbitration code.
`timescale 1ns/100ps
module anpd_progress
	import anpd_pkg::*;
(
	// Clock and reset.
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	// Control from the negotiation logic.
	input  wire logic       clr,
	input  wire logic       rd,
	input  wire logic       done,
	input  wire logic [3:0] code,
	// Held status code.
	output logic      [3:0] held
);

	typedef struct packed {
		logic [3:0] held;
		logic       rd_done;
	} anpd_pm_st_t;

	anpd_pm_st_t s_r;
	anpd_pm_st_t s_nxt;
	logic        frozen;

	// Once complete, only a read or a reset may move the code.
	assign frozen = done && (s_r.held == PM_DONE || s_r.rd_done);

	// Next-state: clear, read load, or upward-only load.
	always_comb
	begin
		s_nxt = s_r;
		if (!done)
			s_nxt.rd_done = 1'b0;
		if (clr)
		begin
			s_nxt = '0;
		end
		else if (rd)
		begin
			s_nxt.held = done ? PM_UP : code;
			s_nxt.rd_done = done;
		end
		else if (!frozen && code > s_r.held)
			s_nxt.held = code;
	end

	// State register.
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign held = s_r.held;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	AST_PM_CLR: assert property (clr |=> held == PM_IDLE)
		else $error("Progress code not cleared by reset.");
	AST_PM_RD: assert property (rd && !clr && !done |=> held == $past(code))
		else $error("Read did not load the present code.");
	AST_PM_UP: assert property (!$past(rd) && !$past(clr) |->
		held >= $past(held))
		else $error("Progress code fell without a read.");
	AST_PM_FROZEN: assert property (done && !rd && !clr &&
		(s_r.rd_done || held == PM_DONE) |=> held == $past(held))
		else $error("Completed code changed without a read.");

endmodule: anpd_progress

// *** tb/anpd_core_tb_top.sv ***
// Self-checking testbench of the negotiation monitor block.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	err_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module anpd_core_tb_top import anpd_pkg::*;;
	logic        ref_clk, rst_b, awvalid, awready, wvalid, wready;
	logic        bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        rx_flp, rx_nlp, rx_idle100, rx_signal, rx_remote_fault;
	logic        page_rcvd, ack_rcvd, res_100, res_fdx, link_ok;
	logic        local_link_fault, flp_tx_en, tech_10_en, tech_100_en;
	logic        adv_remote_fault, fault;
	logic [2:0]  mode;
	int          err_count, n_checks;

	// Device under test with a short negotiation window.
	anpd_core #(.NEG_CYC(30)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.rx_flp(rx_flp), .rx_nlp(rx_nlp), .rx_idle100(rx_idle100),
		.rx_signal(rx_signal), .rx_remote_fault(rx_remote_fault),
		.page_rcvd(page_rcvd), .ack_rcvd(ack_rcvd), .res_100(res_100),
		.res_fdx(res_fdx), .link_ok(link_ok),
		.local_link_fault(local_link_fault), .flp_tx_en(flp_tx_en),
		.tech_10_en(tech_10_en), .tech_100_en(tech_100_en),
		.adv_remote_fault(adv_remote_fault));

	// Far end of the twisted pair.
	anpd_partner i_partner (.ref_clk(ref_clk), .rst_b(rst_b), .mode(mode),
		.fault(fault), .flp_tx_en(flp_tx_en), .rx_flp(rx_flp),
		.rx_nlp(rx_nlp), .rx_idle100(rx_idle100), .rx_signal(rx_signal),
		.rx_remote_fault(rx_remote_fault), .page_rcvd(page_rcvd),
		.ack_rcvd(ack_rcvd));

	// Clock of 100 ns period.
	initial ref_clk = 1'b0;
	always #50 ref_clk = ~ref_clk;

	// Prints the verdict and ends the run.
	task automatic report_and_stop;
		if (err_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask: report_and_stop

	// One bus write; both halves offered together, held until taken.
	task automatic wr(input logic [7:0] a, input logic [15:0] d,
		output logic [1:0] r);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		r = bresp;
	endtask: wr

	// One bus read; rready stays high until the data are sampled.
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask: rd

	// Read of a mapped register, checking response and upper half.
	task automatic rb(input logic [7:0] a, output logic [31:0] d);
		logic [1:0] r;
		rd(a, d, r);
		`CHK("read resp", RESP_OKAY, r)
		`CHK("read upper", 16'h0000, d[31:16])
	endtask: rb

	// Silences the line, then a software reset that leaves negotiation on.
	task automatic srst;
		logic [1:0] r;
		mode <= 3'h0; // A stale partner must not be detected after reset.
		wr(REG_CTRL, 16'h9000, r);
		`CHK("srst resp", RESP_OKAY, r)
		repeat (3) @(posedge ref_clk);
	endtask: srst

	// Polls the basic status word until negotiation reports complete.
	task automatic wait_done;
		logic [31:0] d;
		int          i;
		d = '0;
		for (i = 0; i < 300 && d[STAT_DONE] !== 1'b1; i++)
			rb(REG_STAT, d);
		`CHK("complete", 1'b1, d[STAT_DONE])
	endtask: wait_done

	// Reset values, power-up start and an unmapped address.
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		rb(REG_CTRL, d);
		`CHK("ctrl reset", CTRL_RESET_VAL, d[15:0])
		`CHK("start", 1'b1, flp_tx_en)
		rd(8'h40, d, r);
		`CHK("unmapped rd", RESP_SLVERR, r)
		`CHK("unmapped data", 32'h00000000, d)
		wr(8'h40, 16'h0000, r);
		`CHK("unmapped wr", RESP_SLVERR, r)
	endtask: t_regs

	// One kind of partner from reset to complete, then two monitor reads.
	task automatic t_detect(input logic [2:0] m, input int pb,
		input logic e10, input logic e100, input logic cap);
		logic [31:0] d;
		srst;
		mode <= m;
		link_ok <= 1'b1;
		wait_done;
		`CHK("tech10", e10, tech_10_en)
		`CHK("tech100", e100, tech_100_en)
		rb(REG_EXP, d);
		`CHK("capable", cap, d[EXP_CAP])
		rb(REG_PART, d);
		if (!cap)
			`CHK("partner", 1'b1, d[pb])
		rb(REG_QP, d);
		`CHK("qp first", 4'hF, {d[QP_DONE], d[13:11]})
		`CHK("qp rate", e100, d[QP_RATE])
		`CHK("qp duplex", cap, d[QP_DPX])
		`CHK("qp link", 1'b1, d[QP_LINK])
		rb(REG_QP, d);
		`CHK("qp second", 4'h8, {d[QP_DONE], d[13:11]})
	endtask: t_detect

	// Link pulses and idles together give a detection fault.
	task automatic t_multi;
		logic [31:0] d;
		int          i;
		srst;
		mode <= 3'h3;
		d = '0;
		for (i = 0; i < 100 && d[EXP_PDF] !== 1'b1; i++)
			rb(REG_EXP, d);
		`CHK("detect fault", 1'b1, d[EXP_PDF])
		`CHK("no tech", 2'b00, {tech_10_en, tech_100_en})
	endtask: t_multi

	// Remote and local faults with a silent line.
	task automatic t_fault;
		logic [31:0] d;
		srst;
		mode <= 3'h0;
		fault <= 1'b1;
		local_link_fault <= 1'b1;
		repeat (4) @(posedge ref_clk);
		`CHK("adv out", 1'b1, adv_remote_fault)
		rb(REG_ADV, d);
		`CHK("adv rf", 1'b1, d[ADV_RF])
		rb(REG_STAT, d);
		`CHK("stat rf", 1'b1, d[STAT_RF])
		rb(REG_PART, d);
		`CHK("part rf", 1'b1, d[PART_RF])
		rb(REG_EXT, d);
		`CHK("ext rf", 1'b1, d[EXT_RF])
		rb(REG_QP, d);
		`CHK("qp rf", 1'b1, d[QP_RF])
		`CHK("no signal", 1'b1, d[QP_NOSIG])
		fault <= 1'b0;
		local_link_fault <= 1'b0;
		repeat (3) @(posedge ref_clk);
		`CHK("adv clear", 1'b0, adv_remote_fault)
	endtask: t_fault

	// Link loss, enable toggle, restart bit and software reset.
	task automatic t_restart;
		logic [31:0] d;
		logic [1:0]  r;
		srst;
		mode <= 3'h1;
		wait_done;
		mode <= 3'h0;
		link_ok <= 1'b0;
		repeat (5) @(posedge ref_clk);
		`CHK("loss", 3'b110, {flp_tx_en, tech_10_en, tech_100_en})
		rb(REG_QP, d);
		`CHK("qp kept", 4'hF, {d[QP_DONE], d[13:11]})
		wr(REG_CTRL, 16'h0000, r);
		repeat (3) @(posedge ref_clk);
		`CHK("disabled", 1'b0, flp_tx_en)
		`CHK("enables off", 2'b00, {tech_10_en, tech_100_en})
		wr(REG_CTRL, 16'h1000, r);
		repeat (3) @(posedge ref_clk);
		`CHK("enabled", 1'b1, flp_tx_en)
		wr(REG_CTRL, 16'h1200, r);
		`CHK("restart resp", RESP_OKAY, r)
		rb(REG_CTRL, d);
		`CHK("restart clears", 16'h1000, d[15:0])
		srst;
		rb(REG_QP, d);
		`CHK("qp done reset", 1'b0, d[QP_DONE])
		`CHK("qp prog reset", 1'b1, d[13:11] <= 3'h1)
	endtask: t_restart

	// Main sequence.
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = '0;
		{mode, fault, link_ok, local_link_fault} = 6'h00;
		{res_100, res_fdx} = 2'b11;
		err_count = 0;
		n_checks = 0;
		rst_b = 1'b0;
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_regs;
		t_detect(3'h1, PART_10HD, 1'b1, 1'b0, 1'b0);
		t_detect(3'h2, PART_100HD, 1'b0, 1'b1, 1'b0);
		t_detect(3'h4, 0, 1'b0, 1'b1, 1'b1);
		t_multi;
		t_fault;
		t_restart;
		report_and_stop;
	end

	// Cuts a hang short.
	initial
	begin
		repeat (30000) @(posedge ref_clk);
		err_count++;
		report_and_stop;
	end
endmodule: anpd_core_tb_top

// *** tb/anpd_partner.sv ***
// Remote link partner model driving the line event inputs.
`timescale 1ns/100ps
module anpd_partner
(
	// Clock and reset.
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	// Behaviour select and local burst activity.
	input  wire logic [2:0] mode,
	input  wire logic       fault,
	input  wire logic       flp_tx_en,
	// Line events seen by the block.
	output logic            rx_flp,
	output logic            rx_nlp,
	output logic            rx_idle100,
	output logic            rx_signal,
	output logic            rx_remote_fault,
	output logic            page_rcvd,
	output logic            ack_rcvd
);
	logic [2:0] cnt;
	logic       neg;

	// A negotiating partner only answers while our bursts are on the line.
	assign neg = (mode == 3'h4) && flp_tx_en;

	// Mode 1 sends link pulses, 2 idles, 3 both at once, 4 burst replies.
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt <= 3'h0;
			{rx_flp, rx_nlp, rx_idle100, rx_signal} <= 4'h0;
			{rx_remote_fault, page_rcvd, ack_rcvd} <= 3'h0;
		end
		else
		begin
			cnt <= cnt + 3'h1;
			rx_nlp <= (mode == 3'h1 || mode == 3'h3) && cnt[1:0] == 2'h0;
			rx_idle100 <= mode == 3'h2 || (mode == 3'h3 && cnt[1:0] == 2'h0);
			rx_flp <= neg && cnt[0];
			rx_signal <= mode != 3'h0;
			rx_remote_fault <= fault;
			page_rcvd <= neg && cnt == 3'h3;
			ack_rcvd <= neg && cnt == 3'h7;
		end
	end
endmodule: anpd_partner
